/* File: rtl/cpg_pkg.sv */
/*
 * Shared constants and types for the core power-good and fault monitor.
 * Assumes a 100 MHz ref_clk and analog comparators that report as logic levels.
 */
// Contract
// - After boot voltage is reached, wait for the pin pull-in current, then start the timer.
// - On current detect, capture the six-bit voltage code and regulate to it.
// - Power-good delay lasts 3072 switching cycles.
// - Power-good stays low until the delay timer has expired.
// - Power-good is blanked during every voltage code change and mode change.
// - Overvoltage or undervoltage comparison violated drives power-good low.
// - Above overvoltage reference: set latch and force modulator low at once.
// - During overvoltage, below the lower threshold turns all switches off.
// - While overvoltage persists, alternate between low-side-on and all-off.
// - Overvoltage latch clears only on power-on reset.
// - Overvoltage reference follows the setpoint of the present mode.
// - Undervoltage reference is a fixed fraction of the present mode's setpoint.
// - Undervoltage for more than 32 consecutive phase cycles latches the converter off.
// - Undervoltage latch holds until power reset or enable toggle.
// - Overcurrent input is the average of active channel sense currents only.
// - Averaged current over threshold enables an up/down phase-cycle counter.
// - Still over threshold at end of 32-count window: power-good low, latch off.
// - Dropping below threshold inside the window lets operation continue normally.
// - Overcurrent is present when average is equal to or above threshold.
// - Mode: stop high, deeper low is active; both low deep; deeper high deeper.
package cpg_pkg;

    // ==========================================================
    // Timing counts, in phase (switching) cycles
    localparam int unsigned PG_DELAY_TICKS = 3072;  // Power-good delay
    localparam int unsigned UV_TRIP_TICKS  = 33;    // More than 32 consecutive
    localparam int unsigned OC_TRIP_TICKS  = 32;    // Window of 32 counts
    localparam int unsigned BLANK_TICKS    = 64;    // Blanking after a change

    // ==========================================================
    // Operating mode, selects setpoint for loop and comparator references
    typedef enum logic [1:0] {
        CPG_MODE_ACTIVE = 2'h0,
        CPG_MODE_DEEP   = 2'h1,
        CPG_MODE_DEEPER = 2'h2
    } cpg_mode_t;

    // ==========================================================
    // Sequencer states, one-hot
    typedef enum logic [5:0] {
        CPG_ST_OFF   = 6'b00_0001,
        CPG_ST_SOFT  = 6'b00_0010,
        CPG_ST_PULL  = 6'b00_0100,
        CPG_ST_DELAY = 6'b00_1000,
        CPG_ST_RUN   = 6'b01_0000,
        CPG_ST_LATCH = 6'b10_0000
    } cpg_state_t;

    // ==========================================================
    // Asynchronous pin inputs, synchronised together
    typedef struct packed {
        logic       enable;        // Converter enable pin
        logic       boot_reached;  // Soft-start reached boot setpoint
        logic       over_ref;      // Sense above overvoltage reference
        logic       above_lower;   // Sense above overvoltage release level
        logic       under_ref;     // Sense below undervoltage reference
        logic       pull_current;  // Pin pull-in current at required level
        logic       stop_n;        // Stop-cpu input, active low
        logic       deeper;        // Deeper sleep input
        logic [5:0] code;          // Voltage identification code
        logic       phase_clk;     // Phase clock from the oscillator
    } cpg_pins_t;

    // Power stage drive commands
    typedef struct packed {
        logic run;        // Modulator allowed to switch
        logic force_low;  // Lower switches on
        logic all_off;    // Both switches off
    } cpg_drive_t;

endpackage : cpg_pkg

/* File: rtl/cpg_fault_filter.sv */
/*
 * Fault filter: counts phase cycles of a fault condition and latches a trip.
 * Assumes tick is a one-cycle pulse and cond is synchronous to ref_clk.
 */
`timescale 1ns/1ps
module cpg_fault_filter #(
    parameter int unsigned LIMIT  = 32,  // Count at which the trip latches
    parameter bit          UPDOWN = 1'b0 // 1: count down when clear, 0: reset
) (
    input  wire logic ref_clk, // System clock
    input  wire logic rstn,    // Async reset, active low
    input  wire logic tick,    // Phase cycle pulse
    input  wire logic cond,    // Fault condition present
    input  wire logic clear,   // Clear the trip latch
    output logic      trip_r   // Latched trip
);
    localparam int unsigned CW = $clog2(LIMIT + 1);
    localparam logic [CW-1:0] LIM = CW'(LIMIT);

    if (LIMIT < 2) begin : g_bad_limit
        $error("cpg_fault_filter: LIMIT too small");
    end

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic          trip_nxt;

    // ==========================================================
    // Count per phase cycle; set wins over clear
    always_comb begin
        cnt_nxt  = cnt_r;
        trip_nxt = trip_r & ~clear;
        if (tick) begin
            if (cond) begin
                if (cnt_r == LIM - 1'b1) begin
                    trip_nxt = 1'b1;
                    cnt_nxt  = '0;
                end else begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end else if (UPDOWN) begin
                cnt_nxt = (cnt_r == '0) ? '0 : cnt_r - 1'b1;
            end else begin
                cnt_nxt = '0;
            end
        end
        if (clear && !(tick && cond && cnt_r == LIM - 1'b1)) begin
            cnt_nxt = '0;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r  <= '0;
            trip_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            trip_r <= trip_nxt;
        end
    end
endmodule // cpg_fault_filter

/* File: rtl/cpg_monitor.sv */
/*
 * Core regulator supervision: start-up sequencing on the shared power-good
 * pin, power-good delay and blanking, overvoltage latch with hysteretic
 * drive, filtered undervoltage and overcurrent shutdown.
 * Assumes comparator and pin inputs are asynchronous and are synchronised
 * here; channel current samples and trip threshold come from converters
 * clocked by ref_clk. rstn is the power-on reset of the chip.
 */
`timescale 1ns/1ps
module cpg_monitor #(
    parameter int unsigned NCH      = 2,                      // Channels
    parameter int unsigned IW       = 8,                      // Sample width
    parameter int unsigned PG_DELAY = cpg_pkg::PG_DELAY_TICKS // Delay ticks
) (
    input  wire logic              ref_clk,                // 100 MHz clock
    input  wire logic              rstn,                   // Power-on reset, low
    input  wire logic              enable_in,              // Enable pin
    input  wire logic              boot_reached,           // Soft-start done
    input  wire logic              over_ref_cmp,           // Above 112 percent
    input  wire logic              above_lower_cmp,        // Above 102 percent
    input  wire logic              under_ref_cmp,          // Below 84 percent
    input  wire logic              pull_current_det,       // Pin current seen
    input  wire logic              stop_cpu_input_n,       // Stop-cpu, low
    input  wire logic              deeper_sleep_input,     // Deeper sleep
    input  wire logic [5:0]        voltage_code,           // Code pins
    input  wire logic              phase_clk,              // Phase clock
    input  wire logic [NCH*IW-1:0] channel_sense_current,  // Samples
    input  wire logic [NCH-1:0]    channel_active,         // Active channels
    input  wire logic [IW-1:0]     current_trip_threshold, // Trip level
    output logic                   power_ok_pin_out,       // Pin drive value
    output logic                   power_ok_pin_oe,        // Pin pulled low
    output cpg_pkg::cpg_drive_t    drive_r,                // Power stage
    output logic                   use_code_r,             // 0 boot, 1 code
    output logic [5:0]             target_code_r,          // Regulated code
    output cpg_pkg::cpg_mode_t     mode_r,                 // Setpoint select
    output logic                   ov_latch_r,             // Overvoltage
    output logic                   uv_trip_r,              // Undervoltage
    output logic                   oc_trip_r               // Overcurrent
);
    localparam int unsigned DW = $clog2(PG_DELAY + 1);
    localparam int unsigned BW = $clog2(cpg_pkg::BLANK_TICKS + 1);
    localparam int unsigned SW = IW + $clog2(NCH + 1);
    localparam logic [DW-1:0] DLY_LAST  = DW'(PG_DELAY - 1);
    localparam logic [BW-1:0] BLANK_LD  = BW'(cpg_pkg::BLANK_TICKS);

    if (NCH < 1 || IW < 1 || PG_DELAY < 1) begin : g_bad_shape
        $error("cpg_monitor: bad channel shape or PG_DELAY below 1");
    end

    // ==========================================================
    // Functions
    // Mode decode from stop and deeper inputs
    function automatic cpg_pkg::cpg_mode_t decode_mode(input logic stop_n,
                                                       input logic deeper);
        if (deeper)      decode_mode = cpg_pkg::CPG_MODE_DEEPER;
        else if (stop_n) decode_mode = cpg_pkg::CPG_MODE_ACTIVE;
        else             decode_mode = cpg_pkg::CPG_MODE_DEEP;
    endfunction

    // ==========================================================
    // Pin synchronisers, two flops each
    cpg_pkg::cpg_pins_t pins_raw;
    cpg_pkg::cpg_pins_t sync1_r;
    cpg_pkg::cpg_pins_t pins_s;
    logic               phase_prev_r;
    logic               enable_prev_r;

    assign pins_raw = '{enable:       enable_in,
                        boot_reached: boot_reached,
                        over_ref:     over_ref_cmp,
                        above_lower:  above_lower_cmp,
                        under_ref:    under_ref_cmp,
                        pull_current: pull_current_det,
                        stop_n:       stop_cpu_input_n,
                        deeper:       deeper_sleep_input,
                        code:         voltage_code,
                        phase_clk:    phase_clk};

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sync1_r       <= '0;
            pins_s        <= '0;
            phase_prev_r  <= 1'b0;
            enable_prev_r <= 1'b0;
        end else begin
            sync1_r       <= pins_raw;
            pins_s        <= sync1_r;
            phase_prev_r  <= pins_s.phase_clk;
            enable_prev_r <= pins_s.enable;
        end
    end

    // Phase cycle tick and enable toggle, taken from the second flop only
    logic tick;
    logic enable_fall;
    assign tick        = pins_s.phase_clk & ~phase_prev_r;
    assign enable_fall = enable_prev_r & ~pins_s.enable;

    // ==========================================================
    // Overcurrent: average of active channels compared without a divider.
    // sum >= threshold * active_count is the same test as avg >= threshold.
    logic [SW-1:0] sum_active;
    logic [SW-1:0] trip_scaled;
    logic          oc_now_r;
    logic          oc_now_nxt;

    always_comb begin
        sum_active  = '0;
        trip_scaled = '0;
        for (int i = 0; i < NCH; i++) begin
            if (channel_active[i]) begin
                sum_active  = sum_active + SW'(channel_sense_current[i*IW +: IW]);
                trip_scaled = trip_scaled + SW'(current_trip_threshold);
            end
        end
        oc_now_nxt = (channel_active != '0) && (sum_active >= trip_scaled);
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) oc_now_r <= 1'b0;
        else       oc_now_r <= oc_now_nxt;
    end

    // ==========================================================
    // Filtered faults, counted only while the converter runs
    cpg_pkg::cpg_state_t state_r;
    cpg_pkg::cpg_state_t state_nxt;
    logic                live;
    assign live = state_r == cpg_pkg::CPG_ST_RUN;

    cpg_fault_filter #(
        .LIMIT  (cpg_pkg::UV_TRIP_TICKS),
        .UPDOWN (1'b0)
    ) u_uv_filter (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .tick    (tick),
        .cond    (live & pins_s.under_ref),
        .clear   (enable_fall),
        .trip_r  (uv_trip_r)
    );

    cpg_fault_filter #(
        .LIMIT  (cpg_pkg::OC_TRIP_TICKS),
        .UPDOWN (1'b1)
    ) u_oc_filter (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .tick    (tick),
        .cond    (live & oc_now_r),
        .clear   (enable_fall),
        .trip_r  (oc_trip_r)
    );

    // ==========================================================
    // Sequencer, timers, overvoltage and pin drive
    logic [DW-1:0]       delay_r;
    logic [DW-1:0]       delay_nxt;
    logic                timer_done_r;
    logic                timer_done_nxt;
    logic [BW-1:0]       blank_r;
    logic [BW-1:0]       blank_nxt;
    logic                ov_latch_nxt;
    logic                ov_low_r;
    logic                ov_low_nxt;
    cpg_pkg::cpg_drive_t drive_nxt;
    logic                use_code_nxt;
    logic [5:0]          target_code_nxt;
    cpg_pkg::cpg_mode_t  mode_nxt;
    logic                pin_oe_nxt;
    logic                fault_any;

    assign fault_any = ov_latch_r | uv_trip_r | oc_trip_r;

    always_comb begin
        state_nxt       = state_r;
        delay_nxt       = delay_r;
        timer_done_nxt  = timer_done_r;
        blank_nxt       = blank_r;
        use_code_nxt    = use_code_r;
        target_code_nxt = target_code_r;
        mode_nxt        = decode_mode(pins_s.stop_n, pins_s.deeper);

        // Overvoltage latch, only power-on reset clears it
        ov_latch_nxt = ov_latch_r | pins_s.over_ref;
        // Hysteretic drive: low-side on above reference, off below release
        if (pins_s.over_ref)          ov_low_nxt = 1'b1;
        else if (!pins_s.above_lower) ov_low_nxt = 1'b0;
        else                          ov_low_nxt = ov_low_r;

        case (state_r)
            cpg_pkg::CPG_ST_OFF: begin
                use_code_nxt   = 1'b0;
                timer_done_nxt = 1'b0;
                if (pins_s.enable && !uv_trip_r && !oc_trip_r) begin
                    state_nxt = cpg_pkg::CPG_ST_SOFT;
                end
            end
            cpg_pkg::CPG_ST_SOFT: begin
                if (pins_s.boot_reached) state_nxt = cpg_pkg::CPG_ST_PULL;
            end
            cpg_pkg::CPG_ST_PULL: begin
                if (pins_s.pull_current) begin
                    target_code_nxt = pins_s.code;
                    use_code_nxt    = 1'b1;
                    delay_nxt       = '0;
                    state_nxt       = cpg_pkg::CPG_ST_DELAY;
                end
            end
            cpg_pkg::CPG_ST_DELAY: begin
                if (tick) begin
                    if (delay_r == DLY_LAST) begin
                        timer_done_nxt = 1'b1;
                        state_nxt      = cpg_pkg::CPG_ST_RUN;
                    end else begin
                        delay_nxt = delay_r + 1'b1;
                    end
                end
            end
            cpg_pkg::CPG_ST_RUN: begin
                // Active mode follows code changes; any change restarts blanking
                if (mode_nxt == cpg_pkg::CPG_MODE_ACTIVE) begin
                    target_code_nxt = pins_s.code;
                end
                if (mode_nxt != mode_r || target_code_nxt != target_code_r) begin
                    blank_nxt = BLANK_LD;
                end else if (tick && blank_r != '0) begin
                    blank_nxt = blank_r - 1'b1;
                end
            end
            cpg_pkg::CPG_ST_LATCH: begin
                // Wait for enable low with the filtered faults cleared
                if (!pins_s.enable && !uv_trip_r && !oc_trip_r) begin
                    state_nxt = cpg_pkg::CPG_ST_OFF;
                end
            end
            default: state_nxt = cpg_pkg::CPG_ST_OFF;
        endcase

        // Faults override every state but off; disable overrides every state but latch
        if (state_r != cpg_pkg::CPG_ST_OFF && fault_any) begin
            state_nxt = cpg_pkg::CPG_ST_LATCH;
        end else if (state_r != cpg_pkg::CPG_ST_LATCH && !pins_s.enable) begin
            state_nxt = cpg_pkg::CPG_ST_OFF;
        end
        if (state_nxt != cpg_pkg::CPG_ST_RUN) blank_nxt = '0;

        // Power stage commands; overvoltage handling has the final word
        drive_nxt.run       = (state_nxt != cpg_pkg::CPG_ST_OFF) &&
                              (state_nxt != cpg_pkg::CPG_ST_LATCH);
        drive_nxt.force_low = ov_latch_nxt & ov_low_nxt;
        drive_nxt.all_off   = ov_latch_nxt ? ~ov_low_nxt
                                           : ~drive_nxt.run;
        if (ov_latch_nxt) drive_nxt.run = 1'b0;

        // Pin is released only after the delay with no fault or blanking
        pin_oe_nxt = !(state_nxt == cpg_pkg::CPG_ST_RUN) ||
                     !timer_done_nxt ||
                     (blank_nxt != '0) ||
                     pins_s.over_ref || pins_s.under_ref ||
                     ov_latch_nxt || uv_trip_r || oc_trip_r;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_r          <= cpg_pkg::CPG_ST_OFF;
            delay_r          <= '0;
            timer_done_r     <= 1'b0;
            blank_r          <= '0;
            ov_latch_r       <= 1'b0;
            ov_low_r         <= 1'b0;
            drive_r          <= '{run: 1'b0, force_low: 1'b0, all_off: 1'b1};
            use_code_r       <= 1'b0;
            target_code_r    <= '0;
            mode_r           <= cpg_pkg::CPG_MODE_ACTIVE;
            power_ok_pin_oe  <= 1'b1;
            power_ok_pin_out <= 1'b0;
        end else begin
            state_r          <= state_nxt;
            delay_r          <= delay_nxt;
            timer_done_r     <= timer_done_nxt;
            blank_r          <= blank_nxt;
            ov_latch_r       <= ov_latch_nxt;
            ov_low_r         <= ov_low_nxt;
            drive_r          <= drive_nxt;
            use_code_r       <= use_code_nxt;
            target_code_r    <= target_code_nxt;
            mode_r           <= mode_nxt;
            power_ok_pin_oe  <= pin_oe_nxt;
            power_ok_pin_out <= 1'b0; // Open drain: only ever pulls low
        end
    end
endmodule // cpg_monitor

/* File: verification/cpg_monitor_properties.sv */
/* Port checker for cpg_monitor.
   Bound from the bench top file; sees top ports only. */
`timescale 1ns/1ps
module cpg_monitor_properties #(
    parameter int unsigned PG_DELAY = 8 // Delay ticks
) (
    input wire logic                ref_clk,            // Clock
    input wire logic                rstn,               // Reset, low
    input wire logic                under_ref_cmp,      // Below low ref
    input wire logic                above_lower_cmp,    // Above release
    input wire logic                pull_current_det,   // Pin current
    input wire logic                deeper_sleep_input, // Deeper
    input wire logic                power_ok_pin_out,   // Pin value
    input wire logic                power_ok_pin_oe,    // Pin pulled
    input wire cpg_pkg::cpg_drive_t drive_r,            // Stage
    input wire cpg_pkg::cpg_mode_t  mode_r,             // Mode
    input wire logic                use_code_r,         // Code used
    input wire logic                ov_latch_r,         // Excess latch
    input wire logic                uv_trip_r,          // Low trip
    input wire logic                oc_trip_r           // Current trip
);
    // ==========
    // Cycles low in a row; saturates so long faults never wrap
    logic [9:0] low_run_r, low_run_nxt;
    always_comb low_run_nxt = under_ref_cmp ? low_run_r + {9'h000, ~&low_run_r} : 10'h000;
    always_ff @(posedge ref_clk or negedge rstn)
        if (!rstn) low_run_r <= 10'h000;
        else low_run_r <= low_run_nxt;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    AST_PIN_OUT:
        assert property (power_ok_pin_out == 1'b0) else $error("pin value not low");
    AST_OV_SET:
        assert property ($rose(ov_latch_r) |-> drive_r.force_low && !drive_r.run &&
            power_ok_pin_oe) else $error("latch set without low drive");
    AST_OV_HOLD:
        assert property (ov_latch_r |=> ov_latch_r) else $error("excess latch cleared");
    AST_FAULT_PG:
        assert property ((ov_latch_r || uv_trip_r || oc_trip_r) [*2] |-> power_ok_pin_oe)
            else $error("pin released under fault");
    AST_PULL:
        assert property ($rose(use_code_r) |-> $past(pull_current_det, 3))
            else $error("code taken without pin current");
    AST_PG_DELAY:
        assert property ($fell(power_ok_pin_oe) |-> $past(use_code_r, PG_DELAY))
            else $error("pin released before delay");
    AST_UV_COUNT:
        assert property ($rose(uv_trip_r) |-> low_run_r >= 10'h021)
            else $error("low trip too early");
    AST_DRIVE:
        assert property (!(drive_r.force_low && drive_r.all_off) &&
            !(drive_r.run && drive_r.all_off)) else $error("stage command clash");
    AST_OV_REL:
        assert property (ov_latch_r && $fell(above_lower_cmp) |-> ##[1:4] drive_r.all_off)
            else $error("switches not off on release");
    AST_MODE:
        assert property ((deeper_sleep_input && use_code_r) [*5] |->
            mode_r == cpg_pkg::CPG_MODE_DEEPER) else $error("deeper mode not taken");
    cover property ($rose(ov_latch_r));
    cover property ($rose(uv_trip_r));
    cover property ($fell(power_ok_pin_oe));
endmodule // cpg_monitor_properties

/* File: verification/cpg_partner.sv */
/* Companion supplies and oscillator model.
   Assumes the bench says when the supplies regulate. */
`timescale 1ns/1ps
module cpg_partner (
    input  wire logic supplies_ok,      // Companions regulate
    input  wire logic power_ok_pin_oe,  // Monitor sinks pin
    output logic      phase_clk,        // Switching clock
    output logic      pull_current_det, // Sink current seen
    output logic      system_power_ok   // Wire-OR of pins
);
    // ==========
    // Free-running oscillator, 40 ns per tick
    initial phase_clk = 1'b0;
    always #20 phase_clk = ~phase_clk;
    // Companions hold the line low until they regulate: no current before
    assign pull_current_det = supplies_ok && power_ok_pin_oe;
    assign system_power_ok  = supplies_ok && !power_ok_pin_oe;
endmodule // cpg_partner

/* File: verification/cpg_monitor_bench.sv */
/* Self-checking bench for cpg_monitor with the companion model.
   Assumes comparator levels come straight from the bench. */
`timescale 1ns/1ps
module cpg_monitor_bench;
    localparam int unsigned PGD = 8; // Short delay keeps the run brief
    logic ref_clk = 1'b0, rstn = 1'b0, enable_in = 1'b0, boot_reached = 1'b0;
    logic over_ref_cmp = 1'b0, above_lower_cmp = 1'b0, under_ref_cmp = 1'b0;
    logic stop_cpu_input_n = 1'b1, deeper_sleep_input = 1'b0, supplies_ok = 1'b0;
    logic [5:0]  voltage_code = 6'h2a;
    logic [15:0] channel_sense_current = 16'h0000;
    logic [1:0]  channel_active = 2'h3;
    logic [7:0]  current_trip_threshold = 8'h40;
    logic phase_clk, pull_current_det, system_power_ok, power_ok_pin_out, power_ok_pin_oe;
    logic use_code_r, ov_latch_r, uv_trip_r, oc_trip_r;
    logic [5:0]          target_code_r;
    cpg_pkg::cpg_drive_t drive_r;
    cpg_pkg::cpg_mode_t  mode_r;
    int n_mismatch = 0, compares = 0;
    // ==========
    always #5 ref_clk = ~ref_clk;
    cpg_monitor #(.PG_DELAY(PGD)) dut_u (.*);
    cpg_partner partner_u (.*);
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk1(input string what, input logic exp, input logic got);
        chk(what, {7'h00, exp}, {7'h00, got});
    endtask
    // Bounded wait for the pin; a timeout shows as a mismatch
    task automatic wait_oe(input logic lvl);
        for (int k = 0; k < 2000 && power_ok_pin_oe !== lvl; k++) cyc(1);
        chk1("pin wait", lvl, power_ok_pin_oe);
    endtask
    task automatic complete_run;
        if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Start-up: enable, boot level, companions release, delay, run
    task automatic t_startup;
        enable_in = 1'b1;
        cyc(6);
        boot_reached = 1'b1;
        cyc(6);
        chk1("code before pull", 1'b0, use_code_r);
        supplies_ok = 1'b1;
        cyc(5);
        chk1("code used", 1'b1, use_code_r);
        chk("code taken", {2'h0, voltage_code}, {2'h0, target_code_r});
        cyc(20);
        chk1("pin held in delay", 1'b1, power_ok_pin_oe);
        wait_oe(1'b0);
        chk1("system good", 1'b1, system_power_ok);
    endtask
    // Enable toggle clears filtered trips and restarts
    task automatic t_restart;
        enable_in = 1'b0;
        supplies_ok = 1'b0;
        boot_reached = 1'b0;
        cyc(6);
        chk("trips cleared", 8'h00, {6'h00, uv_trip_r, oc_trip_r});
        t_startup;
    endtask
    // Each mode in turn; any change blanks the pin
    task automatic t_modes;
        logic [1:0] pin_set [3] = '{2'b00, 2'b01, 2'b11};
        logic [1:0] exp_mode [3] = '{2'h1, 2'h2, 2'h2};
        for (int i = 0; i < 3; i++) begin
            {stop_cpu_input_n, deeper_sleep_input} = pin_set[i];
            cyc(4);
            chk("mode", {6'h00, exp_mode[i]}, {6'h00, mode_r});
            chk1("blank", 1'b1, power_ok_pin_oe);
        end
        {stop_cpu_input_n, deeper_sleep_input} = 2'b10;
        voltage_code = 6'h15;
        cyc(8);
        chk("mode", 8'h00, {6'h00, mode_r});
        chk("code follow", 8'h15, {2'h0, target_code_r});
        chk1("blank", 1'b1, power_ok_pin_oe);
        wait_oe(1'b0);
    endtask
    // Average at threshold counts; short burst passes, long one trips
    task automatic t_over_current;
        channel_sense_current = {8'h40, 8'h40};
        cyc(80);
        channel_sense_current = 16'h0000;
        cyc(120);
        chk1("short burst", 1'b0, oc_trip_r);
        chk1("pin after burst", 1'b0, power_ok_pin_oe);
        channel_active = 2'b01; // Idle channel would halve the mean
        channel_sense_current = {8'h00, 8'h40};
        cyc(200);
        chk1("current trip", 1'b1, oc_trip_r);
        chk1("pin on trip", 1'b1, power_ok_pin_oe);
        chk1("stage off", 1'b1, drive_r.all_off);
        channel_sense_current = 16'h0000;
        channel_active = 2'b11;
        t_restart;
    endtask
    // Low output: a clear gap of two ticks restarts the count
    task automatic t_under;
        under_ref_cmp = 1'b1;
        cyc(100);
        chk1("pin on low", 1'b1, power_ok_pin_oe);
        under_ref_cmp = 1'b0;
        cyc(8);
        under_ref_cmp = 1'b1;
        cyc(100);
        chk1("no low trip", 1'b0, uv_trip_r);
        cyc(60);
        chk1("low trip", 1'b1, uv_trip_r);
        under_ref_cmp = 1'b0;
        t_restart;
    endtask
    // Excess voltage: latch, low side, all off, cycle; survives enable
    task automatic t_over_voltage;
        above_lower_cmp = 1'b1;
        over_ref_cmp = 1'b1;
        cyc(4);
        chk1("latch", 1'b1, ov_latch_r);
        chk1("low side", 1'b1, drive_r.force_low);
        over_ref_cmp = 1'b0;
        above_lower_cmp = 1'b0;
        cyc(4);
        chk1("all off", 1'b1, drive_r.all_off);
        above_lower_cmp = 1'b1;
        over_ref_cmp = 1'b1;
        cyc(4);
        chk1("low side again", 1'b1, drive_r.force_low);
        over_ref_cmp = 1'b0;
        above_lower_cmp = 1'b0;
        enable_in = 1'b0;
        cyc(6);
        chk1("latch kept", 1'b1, ov_latch_r);
        chk1("pin held", 1'b1, power_ok_pin_oe);
    endtask
    initial begin
        cyc(16);
        rstn = 1'b1;
        cyc(2);
        chk1("reset pin", 1'b1, power_ok_pin_oe);
        chk("reset stage", 8'h01, {5'h00, drive_r});
        t_startup;
        t_modes;
        t_over_current;
        t_under;
        t_over_voltage;
        complete_run;
    end
    // Tests need about 1200 cycles; far more means a hang
    initial begin
        #600000;
        n_mismatch++;
        complete_run;
    end
endmodule // cpg_monitor_bench
bind cpg_monitor cpg_monitor_properties #(.PG_DELAY(PG_DELAY)) props_u (.*);
